// ==== design/relay_defs.svh ====
// Constants for the second relay output function selector.
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------
`define REG_FUNC_SEL 12'h000
`define REG_UPPER 12'h004
`define REG_LOWER 12'h008
`define REG_QTY_SEL 12'h00C
`define REG_STATUS 12'h010

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define STAT_RELAY_BIT 0
`define STAT_LIMIT_BIT 1
`define FUNC_SEL_RESET 4'h0
`define UPPER_RESET 16'h0000
`define LOWER_RESET 16'h0000
`define QTY_SEL_RESET 2'h0

// ----------------------------------------------------------------------
// AXI responses.
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== design/relay_hysteresis.sv ====
// Hysteresis comparator for the limit-based relay functions.
`default_nettype none
module relay_hysteresis #(
	parameter int WIDTH = 16
) (
	input wire logic clk, // Control clock.
	input wire logic rst_n, // Synchronised reset, active low.
	input wire logic [WIDTH-1:0] value, // Quantity under test.
	input wire logic [WIDTH-1:0] upper, // Upper threshold.
	input wire logic [WIDTH-1:0] lower, // Lower threshold.
	output logic state // Comparator output.
);
	// ------------------------------------------------------------------
	// Comparator state.
	// ------------------------------------------------------------------
	wire logic above = value > upper;
	wire logic below = value < lower;
	logic next_state;

	// Rise above upper sets, fall below lower clears, else hold.
	assign next_state = above ? 1'b1 :
		(below ? 1'b0 : state);

	// Starts low so the relay stays open until the limit is crossed.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= 1'b0;
		end else begin
			state <= next_state;
		end
	end
endmodule // relay_hysteresis
`default_nettype wire

// ==== design/relay_pkg.sv ====
// Types shared by the relay output function selector.
`default_nettype none
package relay_pkg;
	// Status inputs that the drive core offers to the relay.
	typedef struct packed {
		logic running;
		logic healthy;
		logic at_target;
		logic freq_nonzero;
	} drive_status_t;

	// Analog quantities that the limit functions compare.
	typedef struct packed {
		logic [15:0] frequency;
		logic [15:0] current;
		logic [15:0] torque;
		logic [15:0] power;
	} drive_quantity_t;

	typedef enum logic [1:0] {
		QTY_FREQ,
		QTY_CURRENT,
		QTY_TORQUE,
		QTY_POWER
	} quantity_sel_t;
endpackage
`default_nettype wire

// ==== design/relay_two_select.sv ====
// Second relay output function selector with an AXI4-Lite register file.
`include "relay_defs.svh"
`default_nettype none
module relay_two_select (
	input wire logic CLOCK, // Control clock, 10 MHz.
	input wire logic RESET_N, // Asynchronous reset, active low.
	input wire relay_pkg::drive_status_t STATUS, // Drive status flags.
	input wire relay_pkg::drive_quantity_t QUANTITY, // Analog values.
	output logic RELAY_CLOSE, // High closes the relay contacts.
	input wire logic [11:0] AWADDR, // Write address.
	input wire logic AWVALID, // Write address valid.
	output logic AWREADY, // Write address ready.
	input wire logic [31:0] WDATA, // Write data.
	input wire logic [3:0] WSTRB, // Write strobes.
	input wire logic WVALID, // Write data valid.
	output logic WREADY, // Write data ready.
	output logic [1:0] BRESP, // Write response.
	output logic BVALID, // Write response valid.
	input wire logic BREADY, // Write response ready.
	input wire logic [11:0] ARADDR, // Read address.
	input wire logic ARVALID, // Read address valid.
	output logic ARREADY, // Read address ready.
	output logic [31:0] RDATA, // Read data.
	output logic [1:0] RRESP, // Read response.
	output logic RVALID, // Read data valid.
	input wire logic RREADY // Read data ready.
);
	import relay_pkg::*;

	// ------------------------------------------------------------------
	// Reset release.
	// ------------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	// Release is synchronised so all flops leave reset on one edge.
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers.
	// ------------------------------------------------------------------
	logic [3:0] relay_two_function_select;
	logic [15:0] upper_limit_threshold;
	logic [15:0] lower_limit_threshold;
	quantity_sel_t limit_quantity;

	// ------------------------------------------------------------------
	// Write channel.
	// ------------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Address and data are caught in either order; both must be in hand.
	assign AWREADY = !aw_held && !BVALID;
	assign WREADY = !w_held && !BVALID;
	wire logic aw_take = AWVALID && AWREADY;
	wire logic w_take = WVALID && WREADY;
	wire logic aw_have = aw_held || aw_take;
	wire logic w_have = w_held || w_take;
	wire logic do_write = aw_have && w_have && !BVALID;
	wire logic [11:0] wr_addr = aw_held ? aw_addr : AWADDR;
	wire logic [31:0] wr_data = w_held ? w_data : WDATA;
	wire logic [3:0] wr_strb = w_held ? w_strb : WSTRB;

	// Decode of the write target.
	wire logic wr_func = wr_addr == `REG_FUNC_SEL;
	wire logic wr_upper = wr_addr == `REG_UPPER;
	wire logic wr_lower = wr_addr == `REG_LOWER;
	wire logic wr_qty = wr_addr == `REG_QTY_SEL;
	wire logic wr_stat = wr_addr == `REG_STATUS;
	wire logic wr_mapped = wr_func || wr_upper || wr_lower || wr_qty ||
		wr_stat;

	// Byte-lane merge of a 16-bit register with the write strobes.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) res[7:0] = data[7:0];
		if (strb[1]) res[15:8] = data[15:8];
		return res;
	endfunction

	// Holding stages for the channel that arrives first.
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			aw_held <= do_write ? 1'b0 : aw_have;
			w_held <= do_write ? 1'b0 : w_have;
			if (aw_take) aw_addr <= AWADDR;
			if (w_take) w_data <= WDATA;
			if (w_take) w_strb <= WSTRB;
		end
	end

	// Register update and write response.
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			relay_two_function_select <= `FUNC_SEL_RESET;
			upper_limit_threshold <= `UPPER_RESET;
			lower_limit_threshold <= `LOWER_RESET;
			limit_quantity <= quantity_sel_t'(`QTY_SEL_RESET);
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
		end else begin
			if (do_write && wr_func && wr_strb[0])
				relay_two_function_select <= wr_data[3:0];
			if (do_write && wr_upper)
				upper_limit_threshold <= merge16(upper_limit_threshold,
					wr_data, wr_strb);
			if (do_write && wr_lower)
				lower_limit_threshold <= merge16(lower_limit_threshold,
					wr_data, wr_strb);
			if (do_write && wr_qty && wr_strb[0])
				limit_quantity <= quantity_sel_t'(wr_data[1:0]);
			if (do_write) begin
				BVALID <= 1'b1;
				BRESP <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Relay function evaluation.
	// ------------------------------------------------------------------
	logic [15:0] limit_value;
	logic limit_state;
	logic fixed_state;
	logic next_relay;

	// The quantity for the limit functions; settings 4 to 7 fix it
	// and the quantity register alone picks it for the shared setting 4'hE.
	always_comb begin
		case (relay_two_function_select)
			4'h4: limit_value = QUANTITY.frequency;
			4'h5: limit_value = QUANTITY.current;
			4'h6: limit_value = QUANTITY.torque;
			4'h7: limit_value = QUANTITY.power;
			default: begin
				case (limit_quantity)
					QTY_FREQ: limit_value = QUANTITY.frequency;
					QTY_CURRENT: limit_value = QUANTITY.current;
					QTY_TORQUE: limit_value = QUANTITY.torque;
					default: limit_value = QUANTITY.power;
				endcase
			end
		endcase
	end

	relay_hysteresis #(
		.WIDTH(16)
	) u_limit (
		.clk(CLOCK),
		.rst_n(rst_n),
		.value(limit_value),
		.upper(upper_limit_threshold),
		.lower(lower_limit_threshold),
		.state(limit_state)
	);

	// Fixed-condition settings; unknown settings leave the relay open.
	always_comb begin
		case (relay_two_function_select)
			4'h0: fixed_state = STATUS.running;
			4'h1: fixed_state = STATUS.healthy;
			4'h2: fixed_state = STATUS.at_target;
			4'h3: fixed_state = STATUS.freq_nonzero;
			default: fixed_state = 1'b0;
		endcase
	end

	wire logic is_limit = (relay_two_function_select >= 4'h4 &&
		relay_two_function_select <= 4'h7) ||
		relay_two_function_select == 4'hE;
	assign next_relay = is_limit ? limit_state : fixed_state;

	// Registered drive so the contact never sees a decode glitch.
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			RELAY_CLOSE <= 1'b0;
		end else begin
			RELAY_CLOSE <= next_relay;
		end
	end

	// ------------------------------------------------------------------
	// Read channel.
	// ------------------------------------------------------------------
	assign ARREADY = !RVALID;
	wire logic ar_take = ARVALID && ARREADY;
	wire logic rd_func = ARADDR == `REG_FUNC_SEL;
	wire logic rd_upper = ARADDR == `REG_UPPER;
	wire logic rd_lower = ARADDR == `REG_LOWER;
	wire logic rd_qty = ARADDR == `REG_QTY_SEL;
	wire logic rd_stat = ARADDR == `REG_STATUS;
	logic [31:0] rd_word;
	logic [31:0] stat_word;

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`STAT_RELAY_BIT] = RELAY_CLOSE;
		stat_word[`STAT_LIMIT_BIT] = limit_state;
	end

	assign rd_word = rd_func ? {28'h0000000, relay_two_function_select} :
		rd_upper ? {16'h0000, upper_limit_threshold} :
		rd_lower ? {16'h0000, lower_limit_threshold} :
		rd_qty ? {30'h00000000, limit_quantity} :
		rd_stat ? stat_word : 32'h0000_0000;
	wire logic rd_mapped = rd_func || rd_upper || rd_lower || rd_qty ||
		rd_stat;

	// Read data is captured when the address is taken.
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= `RESP_OKAY;
		end else if (ar_take) begin
			RVALID <= 1'b1;
			RDATA <= rd_word;
			RRESP <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (RREADY) begin
			RVALID <= 1'b0;
		end
	end
endmodule // relay_two_select
`default_nettype wire

// ==== tb/relay_load_model.sv ====
// Behavioural contact load on the second relay output.
`default_nettype none
module relay_load_model #(
	parameter int DELAY = 1 // Contact travel in cycles, 0 to 8.
) (
	input wire logic clk, // Control clock.
	input wire logic close, // Coil drive from the selector.
	output logic linked // High while the two contacts touch.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] hist = 8'h00;
	logic [8:0] taps;
	// A slow armature lags the coil, so contacts follow its history.
	always @(posedge clk) hist <= {hist[6:0], close};
	assign taps = {hist, close};
	assign linked = taps[DELAY];
endmodule // relay_load_model
`default_nettype wire

// ==== tb/relay_two_properties.sv ====
// Concurrent checks on the second relay output selector ports.
`include "relay_defs.svh"
`default_nettype none
module relay_two_properties (
	input wire logic CLOCK, // Control clock.
	input wire logic RESET_N, // Reset, active low.
	input wire relay_pkg::drive_status_t STATUS, // Status flags.
	input wire relay_pkg::drive_quantity_t QUANTITY, // Analog values.
	input wire logic RELAY_CLOSE, // Relay drive.
	input wire logic [11:0] AWADDR, // Write address.
	input wire logic AWVALID, // Write address valid.
	input wire logic AWREADY, // Write address ready.
	input wire logic [31:0] WDATA, // Write data.
	input wire logic [3:0] WSTRB, // Write strobes.
	input wire logic WVALID, // Write data valid.
	input wire logic WREADY // Write data ready.
);
	timeunit 1ns;
	timeprecision 1ns;
	import relay_pkg::*;
	logic [3:0] sel;
	logic [15:0] up;
	logic [15:0] lo;
	logic take;
	// Mirror of the settings; only writes taken whole on one edge are seen.
	// Strobes are honoured, since a partial write moves only the mirror lanes it enables.
	assign take = AWVALID && AWREADY && WVALID && WREADY;
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			sel <= 4'h0;
			up <= 16'h0000;
			lo <= 16'h0000;
		end else if (take) begin
			if (AWADDR == `REG_FUNC_SEL && WSTRB[0])
				sel <= WDATA[3:0];
			if (AWADDR == `REG_UPPER) begin
				if (WSTRB[0]) up[7:0] <= WDATA[7:0];
				if (WSTRB[1]) up[15:8] <= WDATA[15:8];
			end
			if (AWADDR == `REG_LOWER) begin
				if (WSTRB[0]) lo[7:0] <= WDATA[7:0];
				if (WSTRB[1]) lo[15:8] <= WDATA[15:8];
			end
		end
	end
	// One clock domain, so clocking and disable are shared.
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	run_follow_a: assert property (
		sel == 4'h0 |=> RELAY_CLOSE == $past(STATUS.running))
		else $error("relay not following run flag");
	healthy_follow_a: assert property (
		sel == 4'h1 |=> RELAY_CLOSE == $past(STATUS.healthy))
		else $error("relay not following healthy flag");
	target_follow_a: assert property (
		sel == 4'h2 |=> RELAY_CLOSE == $past(STATUS.at_target))
		else $error("relay not following target flag");
	nonzero_follow_a: assert property (
		sel == 4'h3 |=> RELAY_CLOSE == $past(STATUS.freq_nonzero))
		else $error("relay not following nonzero flag");
	limit_set_a: assert property (
		(sel == 4'h4 && QUANTITY.frequency > up) [*2] |=> RELAY_CLOSE)
		else $error("relay open above upper limit");
	limit_clear_a: assert property (
		(sel == 4'h4 && QUANTITY.frequency < lo) [*2] |=> !RELAY_CLOSE)
		else $error("relay closed below lower limit");
	limit_hold_a: assert property (
		(sel == 4'h4 && QUANTITY.frequency >= lo && QUANTITY.frequency <= up)
		[*2] |=> $stable(RELAY_CLOSE))
		else $error("relay moved between limits");
	reset_open_a: assert property (
		$rose(RESET_N) |-> !RELAY_CLOSE [*2])
		else $error("relay closed while leaving reset");
endmodule // relay_two_properties
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the second relay output selector.
`include "relay_defs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import relay_pkg::*;
	logic CLOCK, RESET_N, RELAY_CLOSE, linked, pred, seen, c;
	drive_status_t STATUS;
	drive_quantity_t QUANTITY;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY;
	logic [33:0] rq[$];
	logic lq[$];
	int err_count, checked;
	relay_two_select relay_two_select_inst (.CLOCK, .RESET_N, .STATUS,
		.QUANTITY, .RELAY_CLOSE, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
		.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
		.ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
	relay_load_model #(.DELAY(1)) relay_load_model_inst (.clk(CLOCK),
		.close(RELAY_CLOSE), .linked(linked));
	// Free-running control clock.
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	task automatic check(input logic [33:0] got, input logic [33:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic bound(input int n);
		if (n >= 50) begin
			err_count++;
			finish_test();
		end
	endtask
	// Notes a contact change only when the prediction really moves.
	task automatic expect_relay(input logic v);
		if (v !== pred) lq.push_back(v);
		pred = v;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		n = 0;
		@(posedge CLOCK);
		rq.push_back({r, 32'h0});
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			if (BVALID) BREADY <= 1'b0;
		end while (!BVALID && n < 50);
		bound(n);
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		int n;
		n = 0;
		@(posedge CLOCK);
		rq.push_back(e);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
			if (ARREADY) ARVALID <= 1'b0;
			if (RVALID) RREADY <= 1'b0;
		end while (!RVALID && n < 50);
		bound(n);
	endtask
	// Matches bus answers and contact changes to the oldest note.
	always @(posedge CLOCK) begin
		if (BVALID && BREADY) check({BRESP, 32'h0}, rq.pop_front(), "bresp");
		if (RVALID && RREADY) check({RRESP, RDATA}, rq.pop_front(), "rd");
		if (RESET_N && linked !== seen) begin
			check(34'(linked), lq.size() ? 34'(lq.pop_front()) : 'x, "relay");
			seen = linked;
		end
	end
	// Reset, register defaults, status functions, then the limit settings.
	initial begin
		logic [15:0] vals [8];
		logic [15:0] v;
		logic [3:0] st;
		int f;
		vals = '{16'h9000, 16'h6000, 16'h3000, 16'h6000, 16'h8000, 16'h8001,
			16'h4000, 16'h3FFF};
		{RESET_N, pred, seen, st, STATUS, QUANTITY, AWVALID, WVALID} = '0;
		{AWADDR, ARADDR, WDATA, BREADY, ARVALID, RREADY} = '0;
		WSTRB = 4'hF;
		void'($urandom(32'h54DF));
		repeat (4) @(posedge CLOCK);
		RESET_N <= 1'b1;
		repeat (3) @(posedge CLOCK);
		for (int i = 0; i < 5; i++) rd(12'(4 * i), 34'h0);
		rd(12'h020, {`RESP_SLVERR, 32'h0});
		wr(12'h020, 32'hFFFFFFFF, `RESP_SLVERR);
		for (int s = 0; s < 4; s++) begin
			expect_relay(st[3 - s]);
			wr(`REG_FUNC_SEL, 32'(s), `RESP_OKAY);
			repeat (16) begin
				@(posedge CLOCK);
				st = 4'($urandom);
				STATUS <= st;
				expect_relay(st[3 - s]);
			end
		end
		@(posedge CLOCK);
		STATUS <= 4'hF;
		expect_relay(1'b1);
		expect_relay(1'b0);
		wr(`REG_FUNC_SEL, 32'h9, `RESP_OKAY);
		wr(`REG_UPPER, 32'hFFFF8000, `RESP_OKAY);
		rd(`REG_UPPER, {`RESP_OKAY, 32'h8000});
		// Partial strobes: only the upper lane lands, and a select write
		// without lane zero must leave the setting alone.
		WSTRB <= 4'h2;
		wr(`REG_UPPER, 32'h0000_12FF, `RESP_OKAY);
		rd(`REG_UPPER, {`RESP_OKAY, 32'h1200});
		wr(`REG_FUNC_SEL, 32'h4, `RESP_OKAY);
		rd(`REG_FUNC_SEL, {`RESP_OKAY, 32'h9});
		WSTRB <= 4'hF;
		wr(`REG_UPPER, 32'h8000, `RESP_OKAY);
		wr(`REG_LOWER, 32'h4000, `RESP_OKAY);
		c = 1'b0;
		for (int k = 0; k < 8; k++) begin
			f = k % 4;
			if (k >= 4) wr(`REG_QTY_SEL, 32'(f), `RESP_OKAY);
			wr(`REG_FUNC_SEL, (k < 4) ? 32'(4 + k) : 32'hE, `RESP_OKAY);
			for (int j = 0; j < 14; j++) begin
				v = (j < 8) ? vals[j] : 16'($urandom);
				QUANTITY <= 64'(v) << (48 - 16 * f);
				if (v > 16'h8000) c = 1'b1;
				else if (v < 16'h4000) c = 1'b0;
				expect_relay(c);
				repeat (2) @(posedge CLOCK);
				rd(`REG_STATUS, {`RESP_OKAY, 30'h0, c, c});
			end
			QUANTITY <= '0;
			c = 1'b0;
			expect_relay(1'b0);
			repeat (2) @(posedge CLOCK);
		end
		repeat (4) @(posedge CLOCK);
		check(34'(lq.size()), 34'h0, "pending");
		finish_test();
	end
endmodule // tb_top
bind relay_two_select relay_two_properties relay_two_properties_inst (
	.CLOCK, .RESET_N, .STATUS, .QUANTITY, .RELAY_CLOSE, .AWADDR, .AWVALID,
	.AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY);
`default_nettype wire
